// >>> src/rsrc_pkg.sv
// Shared constants and types for the run/stop/reset control block.
// Assumes a single 250 MHz clock and a synchronous, active-high reset.
package rsrc_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int unsigned NUM_TERMS = 16;
   localparam int unsigned SEL_W = 4;
   localparam int unsigned NUM_OUTS = 16;
   localparam int unsigned ADDR_W = 4;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_CFG = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;

   // Control register fields.
   localparam int unsigned CTRL_START_BIT = 0;
   localparam int unsigned CTRL_DEFAULT_BIT = 1;

   // Configuration register fields.
   localparam int unsigned CFG_STOP_EN_BIT = 0;
   localparam int unsigned CFG_STOP_SEL_LSB = 4;
   localparam int unsigned CFG_RESET_EN_BIT = 8;
   localparam int unsigned CFG_RESET_SEL_LSB = 12;

   // Status register fields.
   localparam int unsigned STAT_MODE_LSB = 0;
   localparam int unsigned STAT_RUN_BIT = 4;
   localparam int unsigned STAT_STOP_IN_BIT = 5;
   localparam int unsigned STAT_RESET_IN_BIT = 6;
   localparam int unsigned STAT_POWER_BIT = 7;

   // Reset values.
   localparam logic RST_START = 1'b0;
   localparam logic RST_DEFAULT = 1'b0;
   localparam logic RST_EN = 1'b0;
   localparam logic [SEL_W-1:0] RST_SEL = 4'h0;
   localparam logic [31:0] RD_ZERO = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Operating modes
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_RESTORE,
      MODE_STOP,
      MODE_RESET,
      MODE_RUN
   } rsrc_mode_t;

endpackage

// >>> src/rsrc_storage_ctl.sv
// Storage command generator: turns the operating mode into clear,
// freeze and timer commands for the data memories of the CPU.
// Assumes the memories act on these levels and pulses every cycle.
module rsrc_storage_ctl (
   input wire logic clock,
   input wire logic rst,
   input wire rsrc_pkg::rsrc_mode_t mode,
   input wire logic restart,
   output logic keep_clear,
   output logic clear_clear,
   output logic exp_clear,
   output logic timer_zero,
   output logic timer_preset,
   output logic storage_freeze
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic keep_clear;
      logic clear_clear;
      logic exp_clear;
      logic timer_zero;
      logic timer_preset;
      logic freeze;
   } rsrc_stor_t;

   rsrc_stor_t s_reg;
   rsrc_stor_t s_next;

   // Reset mode wipes everything, stop mode freezes everything, and a
   // restart clears only clear-type data and reloads timer presets.
   always_comb begin
      s_next = '0;
      unique case (mode)
         rsrc_pkg::MODE_RESET: begin
            s_next.keep_clear = 1'b1;
            s_next.clear_clear = 1'b1;
            s_next.exp_clear = 1'b1;
            s_next.timer_zero = 1'b1;
         end
         rsrc_pkg::MODE_STOP, rsrc_pkg::MODE_RESTORE: begin
            s_next.freeze = 1'b1;
         end
         rsrc_pkg::MODE_RUN: begin
            // Keep-type and expansion data are left alone here.
            s_next.clear_clear = restart;
            s_next.timer_preset = restart;
         end
      endcase
   end

   // Registered so the memories see glitch-free commands.
   always_ff @(posedge clock) begin
      if (rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign keep_clear = s_reg.keep_clear;
   assign clear_clear = s_reg.clear_clear;
   assign exp_clear = s_reg.exp_clear;
   assign timer_zero = s_reg.timer_zero;
   assign timer_preset = s_reg.timer_preset;
   assign storage_freeze = s_reg.freeze;

endmodule

// >>> src/rsrc_top.sv
// Run/stop/reset control for a programmable controller CPU, with an
// Avalon-MM slave for configuration and status.
// Assumes the program engine pulses scan_done at the end of each scan
// and that a battery-backed cell keeps the start bit across power loss.
module rsrc_top (
   input wire logic clock,
   input wire logic rst,
   // Avalon-MM slave.
   input wire logic [rsrc_pkg::ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Field input terminals and supply status.
   input wire logic [rsrc_pkg::NUM_TERMS-1:0] in_terms,
   input wire logic power_good,
   // Battery-backed cell for the start bit.
   input wire logic backup_ok,
   input wire logic retained_start_in,
   output logic retained_start_out,
   // Program engine.
   input wire logic scan_done,
   input wire logic [rsrc_pkg::NUM_OUTS-1:0] out_image,
   output logic [rsrc_pkg::NUM_OUTS-1:0] out_pins,
   output logic exec_enable,
   output logic run_led,
   // Storage commands.
   output logic keep_clear,
   output logic clear_clear,
   output logic exp_clear,
   output logic timer_zero,
   output logic timer_preset,
   output logic storage_freeze
);

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------

   // Picks the selected terminal when the function is enabled.
   function automatic logic term_active(
      input logic en,
      input logic [rsrc_pkg::SEL_W-1:0] sel,
      input logic [rsrc_pkg::NUM_TERMS-1:0] terms
   );
      term_active = en & terms[sel];
   endfunction

   // True in the one mode where the program engine may scan.
   function automatic logic is_running(
      input rsrc_pkg::rsrc_mode_t m
   );
      is_running = (m == rsrc_pkg::MODE_RUN);
   endfunction

   // Merges every enabled byte lane of the written word into an old word.
   function automatic logic [31:0] lane_merge(
      input logic [31:0] old,
      input logic [31:0] wdata,
      input logic [3:0] be
   );
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = wdata[i*8 +: 8];
         end
      end
      lane_merge = res;
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      rsrc_pkg::rsrc_mode_t mode;
      logic start_bit;
      logic default_bit;
      logic stop_en;
      logic [rsrc_pkg::SEL_W-1:0] stop_sel;
      logic reset_en;
      logic [rsrc_pkg::SEL_W-1:0] reset_sel;
      logic stop_smp;
      logic reset_smp;
      logic hold_prev;
      logic restart;
      logic [rsrc_pkg::NUM_OUTS-1:0] outs;
      logic ack;
      logic [31:0] rdata;
   } rsrc_state_t;

   rsrc_state_t s_reg;
   rsrc_state_t s_next;

   logic stop_now;
   logic reset_now;
   logic boundary;
   logic req;
   logic [31:0] ctrl_word;
   logic [31:0] cfg_word;
   logic [31:0] stat_word;
   logic [31:0] wr_word;

   // ----------------------------------------------------------------
   // Input selection and scan boundary
   // ----------------------------------------------------------------

   // Terminal lookups on the live inputs.
   assign stop_now = term_active(s_reg.stop_en, s_reg.stop_sel, in_terms);
   assign reset_now = term_active(s_reg.reset_en, s_reg.reset_sel, in_terms);

   // While the program runs, decisions wait for the end of a scan so
   // the output image never tears; when halted no scans happen, so
   // every clock is a boundary.
   assign boundary = ~is_running(s_reg.mode) | scan_done;

   // ----------------------------------------------------------------
   // Register images
   // ----------------------------------------------------------------

   // Words as seen by software; unused bits read as zero.
   always_comb begin
      ctrl_word = rsrc_pkg::RD_ZERO;
      ctrl_word[rsrc_pkg::CTRL_START_BIT] = s_reg.start_bit;
      ctrl_word[rsrc_pkg::CTRL_DEFAULT_BIT] = s_reg.default_bit;
      cfg_word = rsrc_pkg::RD_ZERO;
      cfg_word[rsrc_pkg::CFG_STOP_EN_BIT] = s_reg.stop_en;
      cfg_word[rsrc_pkg::CFG_STOP_SEL_LSB +: rsrc_pkg::SEL_W] = s_reg.stop_sel;
      cfg_word[rsrc_pkg::CFG_RESET_EN_BIT] = s_reg.reset_en;
      cfg_word[rsrc_pkg::CFG_RESET_SEL_LSB +: rsrc_pkg::SEL_W] = s_reg.reset_sel;
      stat_word = rsrc_pkg::RD_ZERO;
      stat_word[rsrc_pkg::STAT_MODE_LSB +: 2] = s_reg.mode;
      stat_word[rsrc_pkg::STAT_RUN_BIT] = is_running(s_reg.mode);
      stat_word[rsrc_pkg::STAT_STOP_IN_BIT] = s_reg.stop_smp;
      stat_word[rsrc_pkg::STAT_RESET_IN_BIT] = s_reg.reset_smp;
      stat_word[rsrc_pkg::STAT_POWER_BIT] = power_good;
   end

   // Waitrequest drops for one cycle after each request is seen, which
   // gives the read data a full cycle to settle in a flop.
   assign req = read | write;
   assign waitrequest = req & ~s_reg.ack;

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      s_next = s_reg;
      s_next.restart = 1'b0;
      wr_word = RD_ZERO_W();

      // Bus slave: writes take effect on the edge where waitrequest is low; read data is latched one edge earlier.
      s_next.ack = req & ~s_reg.ack;
      if (req & ~s_reg.ack & read) begin
         unique case (address)
            rsrc_pkg::OFS_CTRL: s_next.rdata = ctrl_word;
            rsrc_pkg::OFS_CFG: s_next.rdata = cfg_word;
            rsrc_pkg::OFS_STATUS: s_next.rdata = stat_word;
            default: s_next.rdata = rsrc_pkg::RD_ZERO;
         endcase
      end
      if (write & s_reg.ack) begin
         if (address == rsrc_pkg::OFS_CTRL) begin
            wr_word = lane_merge(ctrl_word, writedata, byteenable);
            // Only software and the restore step touch the start bit.
            s_next.start_bit = wr_word[rsrc_pkg::CTRL_START_BIT];
            s_next.default_bit = wr_word[rsrc_pkg::CTRL_DEFAULT_BIT];
         end else if (address == rsrc_pkg::OFS_CFG) begin
            wr_word = lane_merge(cfg_word, writedata, byteenable);
            s_next.stop_en = wr_word[rsrc_pkg::CFG_STOP_EN_BIT];
            s_next.stop_sel = wr_word[rsrc_pkg::CFG_STOP_SEL_LSB +: rsrc_pkg::SEL_W];
            s_next.reset_en = wr_word[rsrc_pkg::CFG_RESET_EN_BIT];
            s_next.reset_sel = wr_word[rsrc_pkg::CFG_RESET_SEL_LSB +: rsrc_pkg::SEL_W];
         end
      end

      // Mode sequencing, evaluated only at scan boundaries.
      if (boundary) begin
         s_next.stop_smp = stop_now;
         s_next.reset_smp = reset_now;
         s_next.hold_prev = stop_now | reset_now;
         unique case (s_reg.mode)
            rsrc_pkg::MODE_RESTORE: begin
               // Bring back the retained start bit; with a dead battery fall back
               // to the default bit, which reset has just set to RST_DEFAULT (0).
               s_next.start_bit = backup_ok ? retained_start_in : s_reg.default_bit;
               s_next.mode = rsrc_pkg::MODE_STOP;
            end
            rsrc_pkg::MODE_RUN: begin
               if (reset_now) begin
                  s_next.mode = rsrc_pkg::MODE_RESET;
               end else if (stop_now) begin
                  s_next.mode = rsrc_pkg::MODE_STOP;
               end else if (~power_good) begin
                  s_next.mode = rsrc_pkg::MODE_STOP;
               end else if (~s_reg.start_bit & ~s_reg.stop_en) begin
                  // With a stop input designated, clearing the bit is inert.
                  s_next.mode = rsrc_pkg::MODE_STOP;
               end
            end
            rsrc_pkg::MODE_STOP, rsrc_pkg::MODE_RESET: begin
               if (reset_now) begin
                  s_next.mode = rsrc_pkg::MODE_RESET;
               end else if (stop_now) begin
                  s_next.mode = rsrc_pkg::MODE_STOP;
               end else if (power_good & s_reg.start_bit &
                            (~s_reg.stop_en | s_reg.hold_prev | (s_reg.mode == rsrc_pkg::MODE_RESET))) begin
                  // Resume needs the bit set; with a stop input designated
                  // only a release of the inputs restarts the program.
                  s_next.mode = rsrc_pkg::MODE_RUN;
                  s_next.restart = 1'b1;
               end else if (~reset_now) begin
                  s_next.mode = rsrc_pkg::MODE_STOP;
               end
            end
         endcase
      end

      // Outputs follow the image only while running. A scan that ends in
      // the cycle of a restart carries a stale image, so the zero image is
      // kept until the first scan of the resumed program completes.
      if (~is_running(s_next.mode)) begin
         s_next.outs = '0;
      end else if (scan_done & is_running(s_reg.mode)) begin
         s_next.outs = out_image;
      end
   end

   // Zero word sized for the write merge scratch value.
   function automatic logic [31:0] RD_ZERO_W();
      RD_ZERO_W = rsrc_pkg::RD_ZERO;
   endfunction

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------

   // The restore step runs first after reset, so the retained value is
   // caught by a clocked load rather than by the reset itself.
   always_ff @(posedge clock) begin
      if (rst) begin
         s_reg.mode <= rsrc_pkg::MODE_RESTORE;
         s_reg.start_bit <= rsrc_pkg::RST_START;
         s_reg.default_bit <= rsrc_pkg::RST_DEFAULT;
         s_reg.stop_en <= rsrc_pkg::RST_EN;
         s_reg.stop_sel <= rsrc_pkg::RST_SEL;
         s_reg.reset_en <= rsrc_pkg::RST_EN;
         s_reg.reset_sel <= rsrc_pkg::RST_SEL;
         s_reg.stop_smp <= 1'b0;
         s_reg.reset_smp <= 1'b0;
         s_reg.hold_prev <= 1'b0;
         s_reg.restart <= 1'b0;
         s_reg.outs <= '0;
         s_reg.ack <= 1'b0;
         s_reg.rdata <= rsrc_pkg::RD_ZERO;
      end else begin
         s_reg <= s_next;
      end
   end

   // ----------------------------------------------------------------
   // Storage commands
   // ----------------------------------------------------------------
   rsrc_storage_ctl u_storage (
      .clock(clock),
      .rst(rst),
      .mode(s_reg.mode),
      .restart(s_reg.restart),
      .keep_clear(keep_clear),
      .clear_clear(clear_clear),
      .exp_clear(exp_clear),
      .timer_zero(timer_zero),
      .timer_preset(timer_preset),
      .storage_freeze(storage_freeze)
   );

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign readdata = s_reg.rdata;
   assign out_pins = s_reg.outs;
   assign exec_enable = is_running(s_reg.mode);
   assign run_led = is_running(s_reg.mode);
   assign retained_start_out = s_reg.start_bit;

endmodule

// >>> dv/rsrc_props.sv
// Port checker for the run/stop/reset control block.
// Assumes one clock domain and a synchronous, active-high reset.
module rsrc_props (
   input wire logic clock,
   input wire logic rst,
   input wire logic read,
   input wire logic write,
   input wire logic waitrequest,
   input wire logic scan_done,
   input wire logic power_good,
   input wire logic [rsrc_pkg::NUM_OUTS-1:0] out_image,
   input wire logic [rsrc_pkg::NUM_OUTS-1:0] out_pins,
   input wire logic exec_enable,
   input wire logic run_led,
   input wire logic retained_start_out,
   input wire logic keep_clear,
   input wire logic clear_clear,
   input wire logic exp_clear,
   input wire logic timer_zero,
   input wire logic timer_preset,
   input wire logic storage_freeze
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   // Past values are still pre-reset at the first edge after release, hence the reset terms.
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_halt;
      $fell(run_led);
   endsequence
   sequence s_pulse;
      clear_clear ##1 !timer_preset;
   endsequence
   AST_OUT_OFF: assert property (out_pins != 16'h0000 |-> run_led)
      else $error("Outputs driven while halted");
   AST_LED_EXEC: assert property (run_led == exec_enable)
      else $error("Run lamp and execution disagree");
   AST_BOUNDARY: assert property (s_halt |-> $past(scan_done) || !$past(power_good) || $past(rst))
      else $error("Halt away from a scan boundary");
   AST_FREEZE: assert property (s_halt |=> storage_freeze || keep_clear)
      else $error("Halt without freeze or clear");
   AST_RESET_CLR: assert property (keep_clear |-> clear_clear && exp_clear && timer_zero)
      else $error("Reset mode clears incomplete");
   AST_EXP_KEEP: assert property (exp_clear == keep_clear)
      else $error("Expansion storage not handled as keep type");
   AST_RESTART: assert property (timer_preset |-> s_pulse)
      else $error("Restart pulse malformed");
   AST_RISE_ZERO: assert property ($rose(run_led) |-> out_pins == 16'h0000)
      else $error("Outputs changed on restart");
   AST_IMAGE: assert property (run_led && scan_done |=> !run_led || out_pins == $past(out_image))
      else $error("Output image not taken at scan end");
   AST_WAIT: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("Bus answer late");
   AST_START_HELD: assert property ($changed(retained_start_out) |-> $past(write) || $past(rst) || $past(rst, 2))
      else $error("Start bit changed without a write");
endmodule

bind rsrc_top rsrc_props u_props (.clock, .rst, .read, .write, .waitrequest, .scan_done, .power_good,
   .out_image, .out_pins, .exec_enable, .run_led, .retained_start_out, .keep_clear, .clear_clear,
   .exp_clear, .timer_zero, .timer_preset, .storage_freeze);

// >>> dv/rsrc_field_model.sv
// Field side: input terminals, supply, battery cell and a program engine.
// Assumes the bench commands terminal levels, supply and battery health.
module rsrc_field_model #(parameter int SCAN = 8) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [15:0] term_cmd,
   input wire logic supply_cmd,
   input wire logic battery_cmd,
   input wire logic start_store,
   output logic [15:0] in_terms,
   output logic power_good,
   output logic backup_ok,
   output logic retained_start_in = 1'b0,
   output logic scan_done = 1'b0,
   output logic [15:0] out_image = 16'h0001
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt_reg = 8'h00;

   // A scan ends every SCAN cycles; a dead cell yields a changing bit, not a clean one.
   always_ff @(posedge clock) begin
      cnt_reg <= (cnt_reg == 8'(SCAN - 1)) ? 8'h00 : cnt_reg + 8'h01;
      scan_done <= (cnt_reg == 8'(SCAN - 1));
      if (scan_done) begin
         out_image <= {out_image[14:0], ~out_image[15]};
      end
      if (!battery_cmd) begin
         retained_start_in <= ~retained_start_in;
      end else if (!rst) begin
         retained_start_in <= start_store;
      end
      in_terms <= term_cmd;
      power_good <= supply_cmd;
      backup_ok <= battery_cmd;
   end
endmodule

// >>> dv/tb_top.sv
// Self-checking bench for the run/stop/reset control block.
// Assumes the field model and checker sit beside the block.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0;
   logic [3:0] address = 4'h0, byteenable = 4'hf;
   logic [31:0] writedata = 32'h0, readdata, rdata;
   logic [15:0] term_cmd = 16'h0, in_terms, out_image, out_pins;
   logic supply_cmd = 1'b1, battery_cmd = 1'b1, waitrequest, power_good, backup_ok, scan_done;
   logic retained_start_in, retained_start_out, exec_enable, run_led, keep_clear, clear_clear;
   logic exp_clear, timer_zero, timer_preset, storage_freeze;
   int miscompares = 0, n_checks = 0, cyc = 0;

   rsrc_top dut (.clock, .rst, .address, .read, .write, .byteenable, .writedata, .readdata,
      .waitrequest, .in_terms, .power_good, .backup_ok, .retained_start_in, .retained_start_out,
      .scan_done, .out_image, .out_pins, .exec_enable, .run_led, .keep_clear, .clear_clear,
      .exp_clear, .timer_zero, .timer_preset, .storage_freeze);
   rsrc_field_model field (.clock, .rst, .term_cmd, .supply_cmd, .battery_cmd,
      .start_store(retained_start_out), .in_terms, .power_good, .backup_ok, .retained_start_in,
      .scan_done, .out_image);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   initial begin
      forever #2 clock = ~clock;
   end

   // A hang anywhere ends here, well beyond the length of the sequence.
   always @(posedge clock) begin
      cyc++;
      if (cyc == 30000) begin
         miscompares++;
         results();
      end
   end

   task automatic results;
      if (miscompares == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One Avalon access; the request is held until waitrequest is seen low.
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      address <= a;
      writedata <= d;
      read <= !wr;
      write <= wr;
      do @(posedge clock); while (waitrequest !== 1'b0);
      rdata = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic drive(input logic [15:0] t, input logic p, input logic b);
      @(posedge clock);
      term_cmd <= t;
      supply_cmd <= p;
      battery_cmd <= b;
   endtask

   task automatic led_is(input logic v);
      for (int i = 0; i < 60 && run_led !== v; i++) @(negedge clock);
      chk(32'(run_led), 32'(v));
   endtask

   task automatic pulse_rst;
      @(posedge clock);
      rst <= 1'b1;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   // Reset values, unmapped reads, ignored status writes and byte lanes.
   task automatic t_after_reset;
      bus(0, rsrc_pkg::OFS_CTRL, 32'h0);
      chk(rdata, 32'h0);
      bus(0, rsrc_pkg::OFS_CFG, 32'h0);
      chk(rdata, 32'h0);
      bus(0, 4'hc, 32'h0);
      chk(rdata, 32'h0);
      bus(1, rsrc_pkg::OFS_STATUS, 32'hffff_ffff);
      bus(0, rsrc_pkg::OFS_STATUS, 32'h0);
      chk(rdata, 32'h0000_0081);
      byteenable <= 4'h2;
      bus(1, rsrc_pkg::OFS_CFG, 32'hffff_ffff);
      byteenable <= 4'hf;
      bus(0, rsrc_pkg::OFS_CFG, 32'h0);
      chk(rdata, 32'h0000_f100);
      bus(1, rsrc_pkg::OFS_CFG, 32'h0);
   endtask

   task automatic t_run;
      logic [15:0] img;
      bus(1, rsrc_pkg::OFS_CTRL, 32'h1);
      led_is(1);
      @(posedge clock iff scan_done);
      img = out_image;
      @(negedge clock);
      chk(32'(out_pins), 32'(img));
      drive(16'h0, 0, 1);
      led_is(0);
      chk(32'(out_pins), 32'h0);
      drive(16'h0, 1, 1);
      led_is(1);
      bus(1, rsrc_pkg::OFS_CTRL, 32'h0);
      led_is(0);
      bus(1, rsrc_pkg::OFS_CTRL, 32'h1);
      led_is(1);
   endtask

   // Every terminal in turn acts as the stop input; the others must not stop.
   task automatic t_stop;
      for (int k = 0; k < 16; k++) begin
         bus(1, rsrc_pkg::OFS_CFG, 32'h1 | (k << 4));
         drive(~(16'h1 << k), 1, 1);
         repeat (20) @(negedge clock);
         chk(32'(run_led), 32'h1);
         drive(16'h1 << k, 1, 1);
         led_is(0);
         @(negedge clock);
         chk({out_pins, 14'h0, storage_freeze, keep_clear}, 32'h2);
         bus(0, rsrc_pkg::OFS_CTRL, 32'h0);
         chk(rdata, 32'h1);
         drive(16'h0, 1, 1);
         for (int i = 0; i < 60 && timer_preset !== 1'b1; i++) @(negedge clock);
         chk(32'({clear_clear, timer_preset}), 32'h3);
         led_is(1);
      end
   endtask

   task automatic t_reset;
      bus(1, rsrc_pkg::OFS_CFG, 32'h9131);
      drive(16'h0208, 1, 1);
      led_is(0);
      repeat (2) @(negedge clock);
      chk(32'({keep_clear, exp_clear, timer_zero, storage_freeze}), 32'he);
      bus(0, rsrc_pkg::OFS_STATUS, 32'h0);
      chk(rdata, 32'h0000_00e2);
      drive(16'h0, 1, 1);
      led_is(1);
      bus(1, rsrc_pkg::OFS_CTRL, 32'h0);
      repeat (30) @(negedge clock);
      chk(32'(run_led), 32'h1);
      drive(16'h0008, 1, 1);
      led_is(0);
      drive(16'h0, 1, 1);
      repeat (30) @(negedge clock);
      chk(32'(run_led), 32'h0);
      bus(1, rsrc_pkg::OFS_CTRL, 32'h1);
      repeat (30) @(negedge clock);
      chk(32'(run_led), 32'h0);
      drive(16'h0008, 1, 1);
      repeat (3) @(posedge clock);
      drive(16'h0, 1, 1);
      led_is(1);
   endtask

   task automatic t_retain;
      pulse_rst();
      led_is(1);
      bus(0, rsrc_pkg::OFS_CTRL, 32'h0);
      chk(rdata, 32'h1);
      drive(16'h0, 1, 0);
      pulse_rst();
      repeat (30) @(negedge clock);
      chk(32'(run_led), 32'h0);
   endtask

   initial begin
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      t_after_reset();
      t_run();
      t_stop();
      t_reset();
      t_retain();
      results();
   end
endmodule
